// ==== core/sdb_pkg.sv ====
// Purpose: shared types and constants for the burst sram core
// Assumes: one system clock samples all pins
// Notes: widths default to the 18-bit build
package sdb_pkg;
  localparam int WORD_W = 18;
  localparam int ADDR_W = 10;
  localparam int LANE_W = 9;
  localparam int LANES = WORD_W / LANE_W;
  localparam int BURST_LEN = 2;
  localparam int SYNC_STAGES = 3;
  localparam logic [1:0] LAT_ONE_EDGES = 2'h2;
  localparam logic [1:0] LAT_ONEHALF_EDGES = 2'h3;

  typedef enum logic [1:0] {
    SDB_PH_READ  = 2'b00,
    SDB_PH_WRITE = 2'b01,
    SDB_PH_WORD1 = 2'b10
  } sdb_phase_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data0;
    logic [WORD_W-1:0] data1;
    logic [LANES-1:0] lane0_n;
    logic [LANES-1:0] lane1_n;
  } sdb_wreq_t;
endpackage

// ==== core/sdb_sram.sv ====
// Purpose: two-port ddr burst-of-two sram core on a sampling clock
// Assumes: link clocks run far below clock_i; pins pass a 3-stage sync
// Notes: every link clock edge (k rise, k complement rise) is one slot
// Function
// - Read and write ports have separate data buses and run independently.
// - Every read or write moves exactly two words.
// - With loop_disable high read data appears 1.5 clock cycles later.
// - With loop_disable low read data appears 1 clock cycle later.
// - Read and write addresses share one bus: read address on k rise, write address on k complement rise.
// - Each location holds two words of 9, 18 or 36 bits.
// - Words move on each rising edge of both clocks of a pair.
// - Only rising edges of the input clocks are used.
// - Address, data, lane and select inputs are captured on k or its complement; loop_disable is not.
// - Read data leaves output registers stepped by the output clocks.
// - Free-running echo clocks follow the read data timing.
// - Each port acts only when its own select is asserted.
// - Writes finish internally with no more controller timing.
// - Reads return the newest data, including pending writes.
`timescale 1ns/1ps
module sdb_sram #(
  parameter int WORD_W = sdb_pkg::WORD_W,
  parameter int ADDR_W = sdb_pkg::ADDR_W
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic k_i,
  input wire logic k_n_i,
  input wire logic c_i,
  input wire logic c_n_i,
  input wire logic loop_disable_i,
  input wire logic read_port_select_n_i,
  input wire logic write_port_select_n_i,
  input wire logic [sdb_pkg::ADDR_W-1:0] addr_i,
  input wire logic [sdb_pkg::WORD_W-1:0] wdata_i,
  input wire logic [sdb_pkg::LANES-1:0] byte_lane_write_select_n_i,
  output logic [sdb_pkg::WORD_W-1:0] rdata_o,
  output logic echo_clock_o,
  output logic echo_clock_n_o
);
  import sdb_pkg::*;

  localparam int IN_W = 5 + ADDR_W + WORD_W + LANES;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [IN_W-1:0] s1_r, s2_r, s3_r;
  logic [IN_W-1:0] pins;
  assign pins = {k_i, k_n_i, c_i, c_n_i, loop_disable_i, addr_i, wdata_i,
                 byte_lane_write_select_n_i};
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  logic [1:0] sel_s1_r, sel_s2_r, sel_s3_r;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sel_s1_r <= 2'h3;
      sel_s2_r <= 2'h3;
      sel_s3_r <= 2'h3;
    end else begin
      sel_s1_r <= {read_port_select_n_i, write_port_select_n_i};
      sel_s2_r <= sel_s1_r;
      sel_s3_r <= sel_s2_r;
    end
  end

  // clock levels count once stages two and three agree
  logic k_s, kn_s, c_s, cn_s, dis_s, k_old_r, kn_old_r, c_old_r, cn_old_r;
  logic [ADDR_W-1:0] a_s;
  logic [WORD_W-1:0] d_s;
  logic [LANES-1:0] bl_s;
  assign {k_s, kn_s, c_s, cn_s, dis_s, a_s, d_s, bl_s} = s2_r;
  logic k_ok, kn_ok, c_ok, cn_ok;
  assign k_ok = s2_r[IN_W-1] == s3_r[IN_W-1];
  assign kn_ok = s2_r[IN_W-2] == s3_r[IN_W-2];
  assign c_ok = s2_r[IN_W-3] == s3_r[IN_W-3];
  assign cn_ok = s2_r[IN_W-4] == s3_r[IN_W-4];

  logic [3:0] clk_q_r, clk_q_nxt;
  always_comb begin
    clk_q_nxt = clk_q_r;
    if (k_ok) clk_q_nxt[3] = k_s;
    if (kn_ok) clk_q_nxt[2] = kn_s;
    if (c_ok) clk_q_nxt[1] = c_s;
    if (cn_ok) clk_q_nxt[0] = cn_s;
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) clk_q_r <= '0;
    else clk_q_r <= clk_q_nxt;
  end
  assign {k_old_r, kn_old_r, c_old_r, cn_old_r} = clk_q_r;

  // rising edges only; falling edges are never used
  logic k_rise, kn_rise, c_rise, cn_rise;
  assign k_rise = clk_q_nxt[3] & ~k_old_r;
  assign kn_rise = clk_q_nxt[2] & ~kn_old_r;
  assign c_rise = clk_q_nxt[1] & ~c_old_r;
  assign cn_rise = clk_q_nxt[0] & ~cn_old_r;

  // output pair clocks the data; single domain falls back to k pair
  logic c_pair_seen_r;
  logic o_rise, on_rise;
  assign o_rise = c_pair_seen_r ? c_rise : k_rise;
  assign on_rise = c_pair_seen_r ? cn_rise : kn_rise;

  // ----------------------------------------
  // array and input capture
  // ----------------------------------------
  logic [WORD_W-1:0] mem0 [2**ADDR_W];
  logic [WORD_W-1:0] mem1 [2**ADDR_W];

  function automatic logic [WORD_W-1:0] lane_merge(
    input logic [WORD_W-1:0] old_w, input logic [WORD_W-1:0] new_w,
    input logic [LANES-1:0] sel_n);
    logic [WORD_W-1:0] r;
    r = old_w;
    for (int i = 0; i < LANES; i++)
      if (!sel_n[i]) r[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
    return r;
  endfunction

  sdb_phase_t wph_r, wph_nxt;
  logic rd_go, wr_go;
  sdb_wreq_t wq_r, wq_nxt;
  logic wq_pend_r, wq_pend_nxt, wq_commit;
  logic rd_pend_r, rd_pend_nxt;
  logic [ADDR_W-1:0] rd_addr_r, rd_addr_nxt;

  // k rise takes read address, k complement rise takes write address
  assign rd_go = k_rise & ~sel_s3_r[1];
  assign wr_go = kn_rise & ~sel_s3_r[0];

  always_comb begin
    wph_nxt = wph_r;
    wq_nxt = wq_r;
    wq_pend_nxt = wq_pend_r;
    wq_commit = 1'b0;
    rd_pend_nxt = 1'b0;
    rd_addr_nxt = rd_addr_r;
    if (rd_go) begin
      rd_pend_nxt = 1'b1;
      rd_addr_nxt = a_s;
    end
    // commit from the registered copy, so a new capture cannot spoil it
    if (wq_pend_r) begin
      wq_commit = 1'b1;
      wq_pend_nxt = 1'b0;
    end
    // word0 on k rise, word1 on k complement rise
    if (k_rise && !sel_s3_r[0]) begin
      wq_nxt.data0 = d_s;
      wq_nxt.lane0_n = bl_s;
      wph_nxt = SDB_PH_WRITE;
    end else if (wr_go && wph_r == SDB_PH_WRITE) begin
      wq_nxt.addr = a_s;
      wq_nxt.data1 = d_s;
      wq_nxt.lane1_n = bl_s;
      wq_pend_nxt = 1'b1;
      wph_nxt = SDB_PH_READ;
    end
  end

  always_ff @(posedge clock_i) begin
    if (wq_commit) begin
      mem0[wq_r.addr] <= lane_merge(mem0[wq_r.addr], wq_r.data0,
                                    wq_r.lane0_n);
      mem1[wq_r.addr] <= lane_merge(mem1[wq_r.addr], wq_r.data1,
                                    wq_r.lane1_n);
    end
  end

  // ----------------------------------------
  // read pipeline with bypass
  // ----------------------------------------
  logic [WORD_W-1:0] rw0, rw1;
  always_comb begin
    rw0 = mem0[rd_addr_r];
    rw1 = mem1[rd_addr_r];
    if (wq_pend_r && wq_r.addr == rd_addr_r) begin
      rw0 = lane_merge(rw0, wq_r.data0, wq_r.lane0_n);
      rw1 = lane_merge(rw1, wq_r.data1, wq_r.lane1_n);
    end
  end

  // output word queue, one slot per output clock edge
  // back-to-back reads overlap, so each word keeps its own slot
  localparam int OQ_D = int'(LAT_ONEHALF_EDGES) + BURST_LEN - 1;
  logic [WORD_W-1:0] oq_r [OQ_D];
  logic [WORD_W-1:0] oq_nxt [OQ_D];
  logic [OQ_D-1:0] oqv_r, oqv_nxt;
  logic [WORD_W-1:0] rdata_nxt;
  logic echo_nxt, echo_r;
  logic [1:0] lat_edges, w0_idx;
  logic o_step;
  assign lat_edges = dis_s ? LAT_ONEHALF_EDGES : LAT_ONE_EDGES;
  assign o_step = o_rise | on_rise;

  always_comb begin
    oq_nxt = oq_r;
    oqv_nxt = oqv_r;
    rdata_nxt = rdata_o;
    echo_nxt = echo_r;
    w0_idx = lat_edges - 2'h1;
    if (o_rise) echo_nxt = 1'b1;
    if (on_rise) echo_nxt = 1'b0;
    if (o_step) begin
      if (oqv_r[0]) rdata_nxt = oq_r[0];
      for (int i = 0; i < OQ_D - 1; i++) begin
        oq_nxt[i] = oq_r[i+1];
        oqv_nxt[i] = oqv_r[i+1];
      end
      oq_nxt[OQ_D-1] = '0;
      oqv_nxt[OQ_D-1] = 1'b0;
      w0_idx = lat_edges - 2'h2;
    end
    if (rd_pend_r) begin
      oq_nxt[w0_idx] = rw0;
      oqv_nxt[w0_idx] = 1'b1;
      oq_nxt[w0_idx + 2'h1] = rw1;
      oqv_nxt[w0_idx + 2'h1] = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wph_r <= SDB_PH_READ;
      wq_r <= '0;
      wq_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      rd_addr_r <= '0;
      oq_r <= '{default: '0};
      oqv_r <= '0;
      rdata_o <= '0;
      echo_r <= 1'b0;
      c_pair_seen_r <= 1'b0;
    end else begin
      wph_r <= wph_nxt;
      wq_r <= wq_nxt;
      wq_pend_r <= wq_pend_nxt;
      rd_pend_r <= rd_pend_nxt;
      rd_addr_r <= rd_addr_nxt;
      oq_r <= oq_nxt;
      oqv_r <= oqv_nxt;
      rdata_o <= rdata_nxt;
      echo_r <= echo_nxt;
      c_pair_seen_r <= c_pair_seen_r | c_rise;
    end
  end

  assign echo_clock_o = echo_r;
  assign echo_clock_n_o = ~echo_r;
endmodule // sdb_sram

// ==== sim/sdb_ctrl.sv ====
// Purpose: controller model driving the link pins
// Assumes: k period 125 ns, one frame per call
// Notes: pins change mid phase, clear of edges
`timescale 1ns/1ps
module sdb_ctrl (
  output logic k_o,
  output logic k_n_o,
  output logic rd_sel_n_o,
  output logic wr_sel_n_o,
  output logic [sdb_pkg::ADDR_W-1:0] addr_o,
  output logic [sdb_pkg::WORD_W-1:0] wdata_o,
  output logic [sdb_pkg::LANES-1:0] lane_n_o,
  input wire logic [sdb_pkg::WORD_W-1:0] rdata_i
);
  import sdb_pkg::*;
  initial begin
    {k_o, k_n_o, rd_sel_n_o, wr_sel_n_o} = 4'h7;
    addr_o = '0;
    wdata_o = '0;
    lane_n_o = '1;
  end
  // read slot at k rise, write slot at k_n rise
  task automatic frame(input logic rs, input logic [ADDR_W-1:0] ra,
    input logic ws, input sdb_wreq_t w, output logic [WORD_W-1:0] b, a);
    rd_sel_n_o = rs;
    wr_sel_n_o = ws;
    addr_o = ra;
    wdata_o = w.data0;
    lane_n_o = w.lane0_n;
    #10.5 b = rdata_i;
    #4.5 {k_o, k_n_o} = 2'h2;
    #47.5 addr_o = w.addr;
    wdata_o = w.data1;
    lane_n_o = w.lane1_n;
    #10.5 a = rdata_i;
    #4.5 {k_o, k_n_o} = 2'h1;
    #47.5;
  endtask
endmodule // sdb_ctrl

// ==== sim/sdb_sram_checker.sv ====
// Purpose: port checks for the burst sram
// Assumes: output pair idle, so the k pair steps the outputs
// Notes: one clock domain
`timescale 1ns/1ps
module sdb_chk (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic k_i,
  input wire logic k_n_i,
  input wire logic [sdb_pkg::WORD_W-1:0] rdata_o,
  input wire logic echo_clock_o,
  input wire logic echo_clock_n_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_quiet;
    ($stable(k_i) && $stable(k_n_i)) [*8];
  endsequence
  sequence s_echo_hi;
    echo_clock_o [*4];
  endsequence
  property p_pair; echo_clock_o != echo_clock_n_o; endproperty
  property p_rise; $rose(k_i) |-> ##[2:8] $rose(echo_clock_o); endproperty
  property p_fall; $rose(k_n_i) |-> ##[2:8] $fell(echo_clock_o); endproperty
  property p_hi; $rose(echo_clock_o) |=> s_echo_hi; endproperty
  property p_hold; $changed(rdata_o) |=> $stable(rdata_o) [*3]; endproperty
  property p_dq; s_quiet |-> $stable(rdata_o); endproperty
  property p_eq; s_quiet |-> $stable(echo_clock_o); endproperty
  property p_rst; $rose(arst_n_i) |-> !echo_clock_o && rdata_o == '0;
  endproperty
  a_pair: assert property (p_pair) else $error("echo pair");
  a_rise: assert property (p_rise) else $error("echo rise");
  a_fall: assert property (p_fall) else $error("echo fall");
  a_hi: assert property (p_hi) else $error("echo width");
  a_hold: assert property (p_hold) else $error("data step");
  a_dq: assert property (p_dq) else $error("data moved");
  a_eq: assert property (p_eq) else $error("echo moved");
  a_rst: assert property (p_rst) else $error("reset value");
endmodule // sdb_chk
bind sdb_sram sdb_chk u_chk (.clock_i(clock_i), .arst_n_i(arst_n_i),
  .k_i(k_i), .k_n_i(k_n_i), .rdata_o(rdata_o),
  .echo_clock_o(echo_clock_o), .echo_clock_n_o(echo_clock_n_o));

// ==== sim/tb.sv ====
// Purpose: self-checking bench for the burst sram
// Assumes: words sampled late in each output slot
// Notes: output pair idle, k pair steps outputs
`timescale 1ns/1ps
module tb;
  import sdb_pkg::*;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic loop_disable_i = 1'b0;
  logic k, kn, rs_n, ws_n, echo, echo_n;
  logic [ADDR_W-1:0] addr;
  logic [WORD_W-1:0] wdata, rdata;
  logic [LANES-1:0] lanes;
  logic [WORD_W-1:0] sa [32];
  logic [WORD_W-1:0] sb [32];
  int n_mismatch = 0;
  int checked = 0;
  int fn = 0;
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  sdb_sram DUT (.clock_i(clock_i), .arst_n_i(arst_n_i), .k_i(k), .k_n_i(kn),
    .c_i(1'b0), .c_n_i(1'b0), .loop_disable_i(loop_disable_i),
    .read_port_select_n_i(rs_n), .write_port_select_n_i(ws_n),
    .addr_i(addr), .wdata_i(wdata), .byte_lane_write_select_n_i(lanes),
    .rdata_o(rdata), .echo_clock_o(echo), .echo_clock_n_o(echo_n));
  sdb_ctrl P (.k_o(k), .k_n_o(kn), .rd_sel_n_o(rs_n), .wr_sel_n_o(ws_n),
    .addr_o(addr), .wdata_o(wdata), .lane_n_o(lanes), .rdata_i(rdata));
  task automatic cyc(input logic r, input logic [ADDR_W-1:0] ra,
    input logic w, input sdb_wreq_t q);
    logic [WORD_W-1:0] b, a;
    P.frame(r, ra, w, q, b, a);
    sa[fn] = a;
    if (fn > 0) sb[fn-1] = b;
    fn++;
  endtask
  task automatic chk(input int r, input logic [WORD_W-1:0] e0, e1);
    logic [WORD_W-1:0] g0, g1;
    g0 = loop_disable_i ? sb[r+1] : sa[r+1];
    g1 = loop_disable_i ? sa[r+2] : sb[r+1];
    checked++;
    if (g0 !== e0 || g1 !== e1) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h %h want %h %h", $time, g0, g1, e0, e1);
    end
  endtask
  task automatic t_basic(input logic m, input logic [WORD_W-1:0] d0, d1);
    @(posedge clock_i) loop_disable_i <= m;
    cyc(1'b1, '0, 1'b0, '{10'h005, d0, d1, 2'h0, 2'h0});
    cyc(1'b0, 10'h005, 1'b1, '0);
    repeat (2) cyc(1'b1, '0, 1'b1, '0);
    chk(fn-3, d0, d1);
  endtask
  task automatic t_mixed();
    cyc(1'b1, '0, 1'b0, '{10'h3FF, 18'h2AAAA, 18'h15555, 2'h0, 2'h0});
    cyc(1'b0, 10'h005, 1'b0, '{10'h3FF, 18'h3FFFF, 18'h00000, 2'h2, 2'h1});
    cyc(1'b1, '0, 1'b1, '{10'h005, 18'h00000, 18'h00000, 2'h0, 2'h0});
    cyc(1'b0, 10'h005, 1'b1, '0);
    cyc(1'b0, 10'h3FF, 1'b1, '0);
    repeat (2) cyc(1'b1, '0, 1'b1, '0);
    chk(fn-6, 18'h2C4D5, 18'h13B2A);
    chk(fn-4, 18'h2C4D5, 18'h13B2A);
    chk(fn-3, 18'h2ABFF, 18'h00155);
  endtask
  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    t_basic(1'b0, 18'h1A2B3, 18'h04C5D);
    t_basic(1'b1, 18'h2C4D5, 18'h13B2A);
    t_mixed();
    repeat (20) @(posedge clock_i);
    complete_run();
  end
endmodule // tb
